// File: hw/mrsc_top.v
// Purpose: Reset combining, watchdog one and sideband pin control of a mezzanine module.
// Assumes: All pin inputs synchronous to pclk, APB register access.
// Notes: Open-drain pins give output, output enable (low drives) and input.
`include "mrsc_defs.vh"
`default_nettype none

// Functional notes
// R1: Five reset sources: power-up, bus reset, watchdog one, soft bit, debug push.
// R2: A module reset resets processor, system bridge and Ethernet together.
// R3: Reset-out asserts on power-up, watchdog one, debug reset or soft bit.
// R4: Bus reset input resets the module but never asserts reset-out.
// R5: Baseboard feeds reset-out back as bus reset to make module resets.
// R6: Select pin pulled high; grounded means system controller, floating means agent.
// R7: Module-module_n_a output is held permanently low.
// R8: Bus speed pin sampled at power-up; low gives 3:1, high gives 3:2.
// R9: Enumeration-ready driven low from power-up until software clears drive bit.
// R10: Debounced halt input raises an internal interrupt.
// R11: Debounced push button produces a reset-out request.
// R12: Halt and push button inputs are debounced before use.
// R13: Yellow failure LED lights while the board-fail bit is set.
// R14: Green activity LED lights while data bus busy is asserted.
// R15: Second-agent ID select pulled low, second-agent grant pulled high.
// R16: Controller mode routes all four bus interrupts to interrupt inputs.
// R17: Any single bus interrupt line can be asserted toward the host.
// R18: Watchdog one output feeds the auxiliary reset into reset-out.
// R19: Watchdog one enabled after reset with a sixteen second timeout.
// R20: Sources synchronised; reset-out held until every source releases.
module mrsc_top #(
  parameter [31:0] WD_TIMEOUT_CYC = `MRSC_WD_TIMEOUT_S * `MRSC_CLK_HZ
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire bus_reset_n,
  input wire halt_switch_in_n,
  input wire push_button_reset_n,
  input wire data_bus_busy_n,
  input wire controller_sel_n,
  input wire bus_fast_en,
  input wire [3:0] bus_int_in_n,
  input wire enumeration_ready_pin_in,
  output reg enumeration_ready_pin_out,
  output reg enumeration_ready_pin_oe_n,
  output reg reset_out_n,
  output reg module_reset_n,
  output reg module_n_a,
  output reg second_agent_id_select,
  output reg second_agent_grant_n,
  output reg [1:0] clock_ratio,
  output reg [3:0] int_ctrl_ext_in,
  output reg halt_int,
  output reg [3:0] bus_int_out_oe_n,
  output reg fail_led,
  output reg activity_led
);

  // ---------------------------------------------------------------
  // Input synchronisers and debouncers
  // ---------------------------------------------------------------
  reg [1:0] brst_sync_q;
  reg [1:0] halt_sync_q;
  reg [1:0] push_sync_q;
  reg halt_deb_q;
  reg push_deb_q;
  reg [`MRSC_DEB_W-1:0] halt_cnt_q;
  reg [`MRSC_DEB_W-1:0] push_cnt_q;
  wire brst_act = ~brst_sync_q[1];
  wire halt_raw = ~halt_sync_q[1];
  wire push_raw = ~push_sync_q[1];

  // Debounce counter step: clears on agreement, counts up on disagreement.
  function [`MRSC_DEB_W-1:0] deb_next;
    input [`MRSC_DEB_W-1:0] cnt;
    input raw;
    input state;
    begin
      if (raw == state)
        deb_next = {`MRSC_DEB_W{1'b0}};
      else
        deb_next = cnt + 1'b1;
    end
  endfunction

  // True on the last cycle of a full window of disagreement.
  function deb_flip;
    input [`MRSC_DEB_W-1:0] cnt;
    input raw;
    input state;
    begin
      deb_flip = (raw != state) && (cnt == `MRSC_DEB_CYC - 1);
    end
  endfunction

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brst_sync_q <= 2'h0;
      halt_sync_q <= 2'h3;
      push_sync_q <= 2'h3;
      halt_deb_q <= 1'b0;
      push_deb_q <= 1'b0;
      halt_cnt_q <= {`MRSC_DEB_W{1'b0}};
      push_cnt_q <= {`MRSC_DEB_W{1'b0}};
    end
    else
    begin
      brst_sync_q <= {brst_sync_q[0], bus_reset_n}; // [R20]
      halt_sync_q <= {halt_sync_q[0], halt_switch_in_n}; // [R20]
      push_sync_q <= {push_sync_q[0], push_button_reset_n}; // [R20]
      // A level must stay stable for the whole window before it counts.
      halt_cnt_q <= deb_next(halt_cnt_q, halt_raw, halt_deb_q); // [R12]
      push_cnt_q <= deb_next(push_cnt_q, push_raw, push_deb_q); // [R12]
      if (deb_flip(halt_cnt_q, halt_raw, halt_deb_q))
        halt_deb_q <= halt_raw; // [R12]
      if (deb_flip(push_cnt_q, push_raw, push_deb_q))
        push_deb_q <= push_raw; // [R12]
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg soft_module_reset_bit_q;
  reg board_fail_bit_q;
  reg erdy_drive_q;
  reg wd_en_q;
  reg wd_reload_q;
  reg host_int_en_q;
  reg [1:0] host_int_sel_q;
  reg [31:0] wd_load_q;
  reg [31:0] wd_cnt_q;
  reg watchdog_one_q;
  reg wd_fired_q;
  reg halt_pend_q;
  reg [7:0] pur_cnt_q;
  reg pur_q;
  reg strap_done_q;
  reg ctrlr_q;
  wire wr_en = psel & penable & pwrite & pready;
  wire acc_first = psel & penable & ~pready;
  // Control register reset word; its bits give every control field's reset value except the reload strobe, which resets to zero.
  localparam [31:0] CTRL_RST_WORD = `MRSC_CTRL_RST;
  wire [31:0] ctrl_word = {24'h0, host_int_sel_q, host_int_en_q, 1'b0, wd_en_q,
                           erdy_drive_q, board_fail_bit_q, soft_module_reset_bit_q};
  wire [31:0] stat_word = {20'h0, bus_int_in_n, 2'h0, push_deb_q, halt_deb_q,
                           wd_fired_q, bus_fast_en, ctrlr_q, enumeration_ready_pin_in};
  reg [31:0] rd_d;
  reg bad_d;

  always @*
  begin
    rd_d = 32'h0;
    bad_d = 1'b0;
    if (paddr == `MRSC_A_CTRL)
      rd_d = ctrl_word;
    else if (paddr == `MRSC_A_STAT)
      rd_d = stat_word; // [R9]
    else if (paddr == `MRSC_A_WDOG)
      rd_d = wd_cnt_q;
    else if (paddr == `MRSC_A_IRQ)
      rd_d = {31'h0, halt_pend_q};
    else
      bad_d = 1'b1;
  end

  // ---------------------------------------------------------------
  // APB slave response
  // ---------------------------------------------------------------
  // One wait state: ready is registered from the first access cycle and rises in the second, so the decode
  // and the read mux have a whole cycle to settle before data is returned.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= acc_first;
      pslverr <= acc_first & bad_d;
      if (acc_first & ~pwrite)
        prdata <= rd_d;
    end
  end

  // A write lands only at the edge where ready is sampled high.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      soft_module_reset_bit_q <= CTRL_RST_WORD[`MRSC_B_SOFT_RST];
      board_fail_bit_q <= CTRL_RST_WORD[`MRSC_B_BOARD_FAIL];
      erdy_drive_q <= CTRL_RST_WORD[`MRSC_B_ERDY_DRIVE]; // [R9]
      wd_en_q <= CTRL_RST_WORD[`MRSC_B_WD_EN]; // [R19]
      wd_reload_q <= 1'b0;
      host_int_en_q <= CTRL_RST_WORD[`MRSC_B_HOST_INT_EN];
      host_int_sel_q <= CTRL_RST_WORD[`MRSC_F_HOST_INT_LO+1:`MRSC_F_HOST_INT_LO];
      wd_load_q <= 32'h0;
    end
    else
    begin
      // The reload bit is a strobe: it reads back as zero and acts once.
      wd_reload_q <= 1'b0;
      if (wr_en && paddr == `MRSC_A_CTRL)
      begin
        soft_module_reset_bit_q <= pwdata[`MRSC_B_SOFT_RST];
        board_fail_bit_q <= pwdata[`MRSC_B_BOARD_FAIL]; // [R13]
        erdy_drive_q <= pwdata[`MRSC_B_ERDY_DRIVE]; // [R9]
        wd_en_q <= pwdata[`MRSC_B_WD_EN]; // [R19]
        wd_reload_q <= pwdata[`MRSC_B_WD_RELOAD];
        host_int_en_q <= pwdata[`MRSC_B_HOST_INT_EN]; // [R17]
        host_int_sel_q <= pwdata[`MRSC_F_HOST_INT_LO+1:`MRSC_F_HOST_INT_LO]; // [R17]
      end
      if (wr_en && paddr == `MRSC_A_WDOG)
        wd_load_q <= pwdata;
    end
  end

  // ---------------------------------------------------------------
  // Power-up reset stretch and strap capture
  // ---------------------------------------------------------------
  // Straps are caught once, after the stretch, so pins still settling at
  // power-up cannot change the clock ratio or the controller role later.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pur_cnt_q <= 8'h0;
      pur_q <= 1'b1;
      strap_done_q <= 1'b0;
      ctrlr_q <= 1'b0;
      clock_ratio <= `MRSC_RATIO_3TO1;
    end
    else
    begin
      if (pur_cnt_q != `MRSC_PUR_CYC)
        pur_cnt_q <= pur_cnt_q + 8'h1;
      else
        pur_q <= 1'b0;
      if (!strap_done_q && pur_cnt_q == `MRSC_PUR_CYC)
      begin
        strap_done_q <= 1'b1;
        clock_ratio <= bus_fast_en ? `MRSC_RATIO_3TO2 : `MRSC_RATIO_3TO1; // [R8]
        ctrlr_q <= ~controller_sel_n; // [R6]
      end
    end
  end

  // ---------------------------------------------------------------
  // Watchdog one and sticky status flags
  // ---------------------------------------------------------------
  // The counter is held loaded until the straps are caught, so the first
  // timeout is measured from the end of the power-up stretch.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_cnt_q <= 32'h0;
      watchdog_one_q <= 1'b0;
    end
    else
    begin
      if (!strap_done_q || wd_reload_q)
        wd_cnt_q <= (wd_load_q != 32'h0) ? wd_load_q : WD_TIMEOUT_CYC; // [R19]
      else if (wd_en_q && wd_cnt_q != 32'h0)
        wd_cnt_q <= wd_cnt_q - 32'h1;
      // A disabled watchdog never drives the auxiliary reset, even at zero.
      watchdog_one_q <= strap_done_q & wd_en_q & (wd_cnt_q == 32'h0); // [R18]
    end
  end

  // Sticky flags: a new event wins over a write-one clear in the same cycle.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_fired_q <= 1'b0;
      halt_pend_q <= 1'b0;
    end
    else
    begin
      if (watchdog_one_q)
        wd_fired_q <= 1'b1;
      else if (wr_en && paddr == `MRSC_A_STAT && pwdata[`MRSC_B_S_WD_FIRED])
        wd_fired_q <= 1'b0;
      if (halt_deb_q)
        halt_pend_q <= 1'b1; // [R10]
      else if (wr_en && paddr == `MRSC_A_IRQ && pwdata[`MRSC_B_IRQ_HALT])
        halt_pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Reset combining and sideband outputs
  // ---------------------------------------------------------------
  // Bus reset is left out of the reset-out term so the baseboard loop cannot latch.
  wire auxiliary_reset_in = watchdog_one_q; // [R18]
  wire out_req = pur_q | auxiliary_reset_in | push_deb_q | soft_module_reset_bit_q; // [R3] [R4] [R11]

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_out_n <= 1'b0;
      module_reset_n <= 1'b0;
      module_n_a <= 1'b0;
      second_agent_id_select <= 1'b0;
      second_agent_grant_n <= 1'b1;
      enumeration_ready_pin_out <= 1'b0;
      enumeration_ready_pin_oe_n <= 1'b0;
      int_ctrl_ext_in <= 4'h0;
      halt_int <= 1'b0;
      bus_int_out_oe_n <= 4'hf;
      fail_led <= 1'b0;
      activity_led <= 1'b0;
    end
    else
    begin
      reset_out_n <= ~out_req; // [R20] [R1]
      // Processor, bridge and Ethernet share this one reset.
      module_reset_n <= ~(pur_q | brst_act); // [R2] [R4] [R5]
      module_n_a <= 1'b0; // [R7]
      second_agent_id_select <= 1'b0; // [R15]
      second_agent_grant_n <= 1'b1; // [R15]
      enumeration_ready_pin_out <= 1'b0;
      enumeration_ready_pin_oe_n <= ~erdy_drive_q; // [R9]
      int_ctrl_ext_in <= ctrlr_q ? ~bus_int_in_n : 4'h0; // [R16]
      halt_int <= halt_pend_q; // [R10]
      bus_int_out_oe_n <= host_int_en_q ? ~(4'h1 << host_int_sel_q) : 4'hf; // [R17]
      fail_led <= board_fail_bit_q; // [R13]
      activity_led <= ~data_bus_busy_n; // [R14]
    end
  end

endmodule
`default_nettype wire

// File: inc/mrsc_defs.vh
// Purpose: Constants for the module reset and sideband control block.
// Assumes: 100 MHz pclk, APB register access with 32-bit data.
// Notes: Register offsets are byte addresses of aligned words.
`ifndef MRSC_DEFS_VH
`define MRSC_DEFS_VH

`define MRSC_A_CTRL 12'h000
`define MRSC_A_STAT 12'h004
`define MRSC_A_WDOG 12'h008
`define MRSC_A_IRQ 12'h00c

`define MRSC_B_SOFT_RST 0
`define MRSC_B_BOARD_FAIL 1
`define MRSC_B_ERDY_DRIVE 2
`define MRSC_B_WD_EN 3
`define MRSC_B_WD_RELOAD 4
`define MRSC_B_HOST_INT_EN 5
`define MRSC_F_HOST_INT_LO 6

`define MRSC_CTRL_RST 32'h0000_000c

`define MRSC_B_S_ERDY 0
`define MRSC_B_S_CTRLR 1
`define MRSC_B_S_FAST_BUS 2
`define MRSC_B_S_WD_FIRED 3
`define MRSC_B_S_HALT 4
`define MRSC_B_S_PUSH 5
`define MRSC_F_S_BUSINT_LO 8

`define MRSC_B_IRQ_HALT 0

`define MRSC_CLK_HZ 100000000
`define MRSC_WD_TIMEOUT_S 16
`define MRSC_DEB_US 10
`define MRSC_DEB_CYC ((`MRSC_DEB_US * `MRSC_CLK_HZ) / 1000000)
`define MRSC_WD_W 32
`define MRSC_DEB_W 12
`define MRSC_PUR_CYC 8'h10
`define MRSC_RATIO_3TO1 2'h1
`define MRSC_RATIO_3TO2 2'h2

`endif

// File: tb/mrsc_baseboard.sv
// Purpose: Baseboard model that feeds reset-out back as bus reset.
// Assumes: One clock, pclk; enumeration-ready line has a pull-up.
// Notes: host_rst_n lets the bench raise a bus reset of its own.
`default_nettype none
module mrsc_baseboard (
  input wire logic pclk,
  input wire logic reset_out_n,
  input wire logic host_rst_n,
  input wire logic enumeration_ready_pin_out,
  input wire logic enumeration_ready_pin_oe_n,
  output logic bus_reset_n,
  output logic enumeration_ready_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_reset_n = 1'b0;
  always @(posedge pclk)
    bus_reset_n <= reset_out_n & host_rst_n;
  // A released open-drain line floats up to the pull-up level.
  assign enumeration_ready_pin_in =
    enumeration_ready_pin_oe_n ? 1'b1 : enumeration_ready_pin_out;
endmodule
`default_nettype wire

// File: tb/mrsc_top_assertions.sv
// Purpose: Port-level checks of the reset and sideband block.
// Assumes: One clock domain, pclk, with reset presetn.
// Notes: Straps change only while presetn is low.
`default_nettype none
module mrsc_top_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic bus_reset_n,
  input wire logic push_button_reset_n,
  input wire logic data_bus_busy_n,
  input wire logic controller_sel_n,
  input wire logic bus_fast_en,
  input wire logic [3:0] bus_int_in_n,
  input wire logic enumeration_ready_pin_out,
  input wire logic reset_out_n,
  input wire logic module_reset_n,
  input wire logic module_n_a,
  input wire logic second_agent_id_select,
  input wire logic second_agent_grant_n,
  input wire logic [1:0] clock_ratio,
  input wire logic [3:0] int_ctrl_ext_in,
  input wire logic [3:0] bus_int_out_oe_n,
  input wire logic activity_led
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_module_n_a; module_n_a == 1'b0; endproperty
  a_module_n_a: assert property (p_module_n_a) else $error("module_n_a low");
  property p_agent; !second_agent_id_select && second_agent_grant_n; endproperty
  a_agent: assert property (p_agent) else $error("agent pulls");
  property p_led; $past(presetn) |-> activity_led == !$past(data_bus_busy_n); endproperty
  a_led: assert property (p_led) else $error("activity led");
  property p_busrst; !bus_reset_n |-> ##[0:3] !module_reset_n; endproperty
  a_busrst: assert property (p_busrst) else $error("bus reset");
  property p_intin;
    (!controller_sel_n && $stable(bus_int_in_n) && reset_out_n)[*3]
      |-> int_ctrl_ext_in == ~bus_int_in_n;
  endproperty
  a_intin: assert property (p_intin) else $error("int routing");
  property p_onehot; $onehot0(~bus_int_out_oe_n); endproperty
  a_onehot: assert property (p_onehot) else $error("int drive");
  property p_ready; psel && penable && !pready |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  property p_deb; $fell(push_button_reset_n) && reset_out_n |=> reset_out_n[*8]; endproperty
  a_deb: assert property (p_deb) else $error("no debounce");
  property p_ratio;
    reset_out_n && $past(reset_out_n, 2) |-> clock_ratio == (bus_fast_en ? 2'h2 : 2'h1);
  endproperty
  a_ratio: assert property (p_ratio) else $error("clock ratio");
  property p_erdy; enumeration_ready_pin_out == 1'b0; endproperty
  a_erdy: assert property (p_erdy) else $error("erdy level");
endmodule
bind mrsc_top mrsc_top_checker mrsc_top_checker_inst (.pclk, .presetn, .psel, .penable,
  .pready, .bus_reset_n, .push_button_reset_n, .data_bus_busy_n, .controller_sel_n,
  .bus_fast_en, .bus_int_in_n, .enumeration_ready_pin_out, .reset_out_n, .module_reset_n,
  .module_n_a, .second_agent_id_select, .second_agent_grant_n, .clock_ratio,
  .int_ctrl_ext_in, .bus_int_out_oe_n, .activity_led);
`default_nettype wire

// File: tb/module_reset_and_sideband_control_bench.sv
// Purpose: Self-checking bench of the reset and sideband block.
// Assumes: Watchdog one shortened to 200 cycles.
// Notes: Bench acts as system controller on a fast bus, then as agent on a slow bus in t_straps.
`include "mrsc_defs.vh"
`default_nettype none
module module_reset_and_sideband_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, perr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic bus_reset_n, host_rst_n = 1, halt_switch_in_n = 1, push_button_reset_n = 1;
  logic data_bus_busy_n = 1, controller_sel_n = 0, bus_fast_en = 1;
  logic [3:0] bus_int_in_n = 4'hf, int_ctrl_ext_in, bus_int_out_oe_n;
  logic enumeration_ready_pin_in, enumeration_ready_pin_out, enumeration_ready_pin_oe_n;
  logic reset_out_n, module_reset_n, module_n_a, second_agent_id_select;
  logic second_agent_grant_n, halt_int, fail_led, activity_led;
  logic [1:0] clock_ratio;
  int failures = 0, check_count = 0, cyc = 0, n;
  always #5 pclk = ~pclk;
  mrsc_top #(.WD_TIMEOUT_CYC(200)) mrsc_top_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_reset_n, .halt_switch_in_n,
    .push_button_reset_n, .data_bus_busy_n, .controller_sel_n, .bus_fast_en,
    .bus_int_in_n, .enumeration_ready_pin_in, .enumeration_ready_pin_out,
    .enumeration_ready_pin_oe_n, .reset_out_n, .module_reset_n, .module_n_a,
    .second_agent_id_select, .second_agent_grant_n, .clock_ratio, .int_ctrl_ext_in,
    .halt_int, .bus_int_out_oe_n, .fail_led, .activity_led);
  mrsc_baseboard mrsc_baseboard_inst (.pclk, .reset_out_n, .host_rst_n,
    .enumeration_ready_pin_out, .enumeration_ready_pin_oe_n, .bus_reset_n,
    .enumeration_ready_pin_in);
  task automatic summarize;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  // The master holds every request signal until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_ro(input logic v);
    n = 0;
    while (reset_out_n !== v && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    #1;
  endtask
  task automatic t_power_up;
    wait_ro(1);
    chk(clock_ratio, `MRSC_RATIO_3TO2);
    chk(enumeration_ready_pin_oe_n, 0);
    apb(0, `MRSC_A_CTRL, 0);
    chk(rd, `MRSC_CTRL_RST);
    apb(0, `MRSC_A_STAT, 0);
    chk(rd, 32'h0000_0f06);
  endtask
  task automatic t_wdog;
    wait_ro(0);
    chk(n > 100 && n < 300, 1);
    tick(5);
    chk(module_reset_n, 0);
    apb(1, `MRSC_A_CTRL, 32'h04);
    wait_ro(1);
    apb(0, `MRSC_A_STAT, 0);
    chk(rd[3], 1);
    apb(1, `MRSC_A_STAT, 32'h08);
    apb(0, `MRSC_A_STAT, 0);
    chk(rd[3], 0);
    apb(1, `MRSC_A_WDOG, 32'h0000_0100);
    apb(1, `MRSC_A_CTRL, 32'h1c);
    apb(0, `MRSC_A_WDOG, 0);
    chk(rd > 32'h0000_00f0 && rd <= 32'h0000_0100, 1);
    apb(1, `MRSC_A_CTRL, 32'h04);
  endtask
  task automatic t_regs;
    apb(1, `MRSC_A_CTRL, 32'h02);
    tick(2);
    chk(fail_led, 1);
    chk(enumeration_ready_pin_oe_n, 1);
    apb(0, `MRSC_A_STAT, 0);
    chk(rd[0], 1);
    apb(0, 12'h010, 32'h0);
    chk(perr, 1'b1);
    chk(rd, 32'h0);
    apb(1, `MRSC_A_CTRL, 32'h01);
    tick(3);
    chk(reset_out_n, 0);
    tick(4);
    chk({module_reset_n, fail_led}, 0);
    apb(1, `MRSC_A_CTRL, 32'h0);
    wait_ro(1);
    chk(n < 3000, 1);
  endtask
  task automatic t_bus_reset;
    @(posedge pclk);
    host_rst_n <= 1'b0;
    tick(4);
    chk({module_reset_n, reset_out_n}, 2'b01);
    @(posedge pclk);
    host_rst_n <= 1'b1;
    tick(6);
    chk(module_reset_n, 1);
  endtask
  task automatic t_switches;
    @(posedge pclk);
    push_button_reset_n <= 1'b0;
    tick(50);
    @(posedge pclk);
    push_button_reset_n <= 1'b1;
    chk(reset_out_n, 1);
    tick(5);
    @(posedge pclk);
    push_button_reset_n <= 1'b0;
    halt_switch_in_n <= 1'b0;
    wait_ro(0);
    chk(n > 900 && n < 1100, 1);
    tick(100);
    chk(halt_int, 1);
    apb(0, `MRSC_A_IRQ, 0);
    chk(rd[0], 1);
    push_button_reset_n <= 1'b1;
    halt_switch_in_n <= 1'b1;
    wait_ro(1);
    apb(1, `MRSC_A_IRQ, 32'h1);
    tick(2);
    chk(halt_int, 0);
  endtask
  task automatic t_sideband;
    @(posedge pclk);
    data_bus_busy_n <= 1'b0;
    bus_int_in_n <= 4'h5;
    tick(4);
    chk({activity_led, int_ctrl_ext_in}, 5'h1a);
    for (int i = 0; i < 4; i++)
    begin
      apb(1, `MRSC_A_CTRL, 32'h20 | (i << 6));
      tick(2);
      chk(bus_int_out_oe_n, 4'(~(4'h1 << i)));
    end
  endtask
  // A second reset in mid-run with the straps set the other way.
  task automatic t_straps;
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    controller_sel_n <= 1'b1;
    bus_fast_en <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wait_ro(1);
    chk(clock_ratio, `MRSC_RATIO_3TO1);
    chk(int_ctrl_ext_in, 4'h0);
    chk(bus_int_out_oe_n, 4'hf);
    apb(0, `MRSC_A_STAT, 0);
    chk(rd, 32'h0000_0500);
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_power_up();
    t_wdog();
    t_regs();
    t_bus_reset();
    t_switches();
    t_sideband();
    t_straps();
    summarize();
  end
endmodule
`default_nettype wire
